// [pvc_top.sv]
// Per-channel conditioner: fault check, scaling, root, filter, alarms
//
// Operation
// - Temperature, 100 mV and pot inputs flag fault on break or beyond 115%/-15%.
// - Those inputs clamp on break: high gives 115%, low gives -15%.
// - Break confirmed within 5 s (4-wire RTD), 1 s (100 mV), 0.5 s otherwise.
// - 4-20 mA and unipolar voltage ranges flag fault on break or beyond 115%/-15%.
// - Break on 4-20 mA or 1-5 V stores the -15% value.
// - Break on 0-1.25, 0-5 or 0-10 V stores the 0 V value.
// - 0-20 mA flags fault only above 115%; break stores the 0 mA value.
// - Bipolar ranges flag fault beyond 107.5%/-7.5%; break stores the 0 V value.
// - Four level alarms share hysteresis and a 0 to 60 s on/off delay.
// - Change of value measured over 1 to 16 s or one conversion period.
// - High and low rate alarms reuse the level alarm hysteresis and delay.
// - Reported value is the moving average of the last N samples, N 1..128.
// - Root mode outputs sqrt((A-B)*(in-B))+B with A, B the scaling limits.
// - Below about 7% of span at its input the root stage passes input linearly.
// - Root extraction only on DC inputs, never on temperature inputs.
// - Root extraction only when scaling maximum exceeds scaling minimum.
// - All four inputs converted each 60, 10 or 5 ms period.
`timescale 1ns/1ps
module pvc_top import pvc_pkg::*; #(
    parameter int MS_CYCLES = MS_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire pvc_cfg_type              cfg,
    input  wire pvc_alarm_cfg_type        acfg,
    input  wire logic                     disc_pin,
    input  wire logic                     smp_valid,
    output logic                          smp_ready,
    input  wire logic signed [CODE_W-1:0] smp_code,
    output logic                          conv_start,
    output logic                          pv_valid,
    output logic signed [15:0]            pv,
    output logic signed [15:0]            roc,
    output pvc_flags_type                 flags
);
    typedef enum logic [2:0] {ST_IDLE, ST_SCALE, ST_ROOT, ST_AVG, ST_OUT} pvc_st_type;

    typedef struct packed {
        pvc_st_type                st;
        logic [1:0]                disc_sync;
        logic [17:0]               ms_cnt;
        logic [9:0]                sec_ms;
        logic [5:0]                conv_ms;
        logic                      ms_tick;
        logic                      sec_tick;
        logic                      conv_start;
        logic [12:0]               disc_ms;
        logic                      disc_conf;
        logic signed [17:0]        code;
        logic                      fault_p;
        logic signed [15:0]        lin;
        logic signed [15:0]        root;
        logic signed [15:0]        pv;
        logic signed [15:0]        last_pv;
        logic signed [15:0]        roc;
        logic [127:0][15:0]        hist;
        logic [6:0]                wp;
        logic [7:0]                cnt;
        logic signed [23:0]        sum;
        logic [4:0]                roc_sec;
        pvc_cfg_type               cfg_seen;
        logic                      pv_valid;
        logic                      fault;
    } pvc_top_state_type;

    pvc_top_state_type  s_q;
    pvc_top_state_type  s_d;
    logic               f_valid;
    logic               f_ready;
    logic [CODE_W-1:0]  f_data;
    logic [5:0]         alm;
    logic [5:0][15:0]   a_th;
    logic [5:0][15:0]   a_val;
    logic [5:0]         a_up;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
        if (v > 36'sh00007FFF) begin
            return 16'h7FFF;
        end else if (v < -36'sh000008000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    function automatic logic is_temp_grp(input pvc_input_type t);
        return t inside {PVC_RTD4, PVC_RTD, PVC_TC, PVC_MV100, PVC_POT};
    endfunction

    function automatic logic range_fault(input pvc_input_type t,
                                         input logic signed [17:0] c);
        if (t == PVC_I0_20) begin
            return c > C_P115;
        end else if (t inside {PVC_BIP, PVC_UV10}) begin
            return (c > C_P1075) || (c < C_M075);
        end
        return (c > C_P115) || (c < C_M15);
    endfunction

    function automatic logic signed [17:0] break_code(input pvc_input_type t,
                                                       input logic hi);
        if (is_temp_grp(t)) begin
            return hi ? C_P115 : C_M15;
        end else if (t inside {PVC_I4_20, PVC_V1_5}) begin
            return C_M15;
        end else if (t inside {PVC_BIP, PVC_UV10}) begin
            return C_MID;
        end
        return C_ZERO;
    endfunction

    function automatic logic [12:0] break_ms(input pvc_input_type t);
        if (t == PVC_RTD4) begin
            return DISC_RTD4_MS;
        end else if (t == PVC_MV100) begin
            return DISC_MV_MS;
        end
        return DISC_OTH_MS;
    endfunction

    function automatic logic [17:0] isqrt(input logic [35:0] v);
        logic [17:0] r;
        logic [17:0] c;
        r = '0;
        for (int i = 17; i >= 0; i--) begin
            c = r | (18'h00001 << i);
            if (36'(c) * 36'(c) <= v) begin
                r = c;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Sample buffer
    // ------------------------------------------------------------
    pvc_fifo #(.W(CODE_W), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .in_data   (smp_code),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign f_ready = (s_q.st == ST_IDLE);

    // ------------------------------------------------------------
    // Datapath and timing
    // ------------------------------------------------------------
    always_comb begin
        logic signed [16:0] span;
        logic signed [16:0] dlt;
        logic signed [35:0] prod;
        logic [7:0]         n;
        logic [7:0]         c_n;
        logic signed [23:0] s_n;
        logic signed [15:0] old;
        logic [5:0]         per;
        s_d = s_q;
        span = 17'(s_q.cfg_seen.scale_max) - 17'(s_q.cfg_seen.scale_min);
        dlt  = 17'(s_q.lin) - 17'(cfg.scale_min);
        prod = '0;
        n    = (cfg.avg_n == 8'h00) ? 8'h01 : (cfg.avg_n > AVG_MAX) ? AVG_MAX : cfg.avg_n;
        c_n  = s_q.cnt;
        s_n  = s_q.sum;
        old  = s_q.hist[s_q.wp - n[6:0]];
        per  = (cfg.conv == PVC_CONV_60) ? CONV_A_MS :
               (cfg.conv == PVC_CONV_10) ? CONV_B_MS : CONV_C_MS;
        s_d.disc_sync  = {s_q.disc_sync[0], disc_pin};
        s_d.ms_tick    = (s_q.ms_cnt == 18'(MS_CYCLES - 1));
        s_d.ms_cnt     = s_d.ms_tick ? '0 : s_q.ms_cnt + 18'h00001;
        s_d.sec_tick   = 1'b0;
        s_d.conv_start = 1'b0;
        s_d.pv_valid   = 1'b0;
        s_d.cfg_seen   = cfg;
        if (s_q.ms_tick) begin
            s_d.sec_ms  = s_q.sec_ms + 10'h001;
            s_d.conv_ms = s_q.conv_ms + 6'h01;
            if (s_q.sec_ms == 10'(SEC_MS - 1)) begin
                s_d.sec_ms   = '0;
                s_d.sec_tick = 1'b1;
            end
            if (s_q.conv_ms + 6'h01 >= per) begin
                s_d.conv_ms    = '0;
                s_d.conv_start = 1'b1;
            end
        end
        // Break must persist before it counts; short glitches are ignored
        if (!s_q.disc_sync[1]) begin
            s_d.disc_ms   = '0;
            s_d.disc_conf = 1'b0;
        end else if (s_q.ms_tick && !s_q.disc_conf) begin
            s_d.disc_ms = s_q.disc_ms + 13'h0001;
            if (s_q.disc_ms + 13'h0001 >= break_ms(cfg.itype)) begin
                s_d.disc_conf = 1'b1;
            end
        end
        if (s_q.sec_tick && s_q.roc_sec < ROC_MAX_S) begin
            s_d.roc_sec = s_q.roc_sec + 5'h01;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (f_valid) begin
                    s_d.st = ST_SCALE;
                    // 0-20 mA has no low limit, so a break alone is no fault
                    s_d.fault_p = range_fault(cfg.itype, f_data) ||
                                  (s_q.disc_conf && cfg.itype != PVC_I0_20);
                    s_d.code = s_q.disc_conf ? break_code(cfg.itype, cfg.clamp_high)
                                             : f_data;
                end
            end
            ST_SCALE: begin
                prod  = 36'(span) * 36'(s_q.code);
                s_d.lin = sat16((prod >>> FULL_SH) + 36'(s_q.cfg_seen.scale_min));
                s_d.st  = ST_ROOT;
            end
            ST_ROOT: begin
                s_d.root = s_q.lin;
                // Dropout keeps the steep low end of the curve from amplifying noise
                if (cfg.sqrt_en && !is_temp_grp(cfg.itype) && cfg.itype != PVC_POT &&
                    cfg.scale_max > cfg.scale_min && dlt > 17'sh00000 &&
                    36'(dlt) * 36'sd100 > 36'(span) * 36'(SQRT_DROP)) begin
                    prod = 36'(span) * 36'(dlt);
                    s_d.root = sat16(36'(isqrt(prod)) + 36'(cfg.scale_min));
                end
                s_d.st = ST_AVG;
            end
            ST_AVG: begin
                if (s_q.cnt < n) begin
                    c_n = s_q.cnt + 8'h01;
                    s_n = s_q.sum + 24'(s_q.root);
                end else begin
                    s_n = s_q.sum + 24'(s_q.root) - 24'(old);
                end
                s_d.hist[s_q.wp] = s_q.root;
                s_d.wp  = s_q.wp + 7'h01;
                s_d.cnt = c_n;
                s_d.sum = s_n;
                s_d.pv  = sat16(36'(s_n / $signed({1'b0, c_n})));
                s_d.st  = ST_OUT;
            end
            ST_OUT: begin
                if (cfg.roc_s == 5'h00 || s_q.roc_sec >= cfg.roc_s) begin
                    s_d.roc     = sat16(36'(s_q.pv) - 36'(s_q.last_pv));
                    s_d.last_pv = s_q.pv;
                    s_d.roc_sec = '0;
                end
                s_d.fault    = s_q.fault_p;
                s_d.pv_valid = 1'b1;
                s_d.st       = ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // New settings restart the filter so stale samples never mix in
        if (cfg != s_q.cfg_seen) begin
            s_d.cnt = '0;
            s_d.sum = '0;
            s_d.wp  = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Alarms
    // ------------------------------------------------------------
    assign a_th  = {acfg.roc_low, acfg.roc_high, acfg.lower, acfg.lower_critical,
                    acfg.upper, acfg.upper_critical};
    assign a_val = {s_q.roc, s_q.roc, s_q.pv, s_q.pv, s_q.pv, s_q.pv};
    assign a_up  = 6'h13;

    for (genvar i = 0; i < 6; i++) begin : g_alm
        pvc_alarm u_alarm (
            .clk      (clk),
            .rst      (rst),
            .sec_tick (s_q.sec_tick),
            .upper    (a_up[i]),
            .value    (a_val[i]),
            .thresh   (a_th[i]),
            .hyst     (acfg.hyst),
            .delay_s  (acfg.delay_s),
            .active   (alm[i])
        );
    end

    assign flags = '{fault: s_q.fault, upper_critical_alarm: alm[0], upper_alarm: alm[1],
                     lower_critical_alarm: alm[2], lower_alarm: alm[3],
                     roc_high_alarm: alm[4], roc_low_alarm: alm[5]};
    assign pv         = s_q.pv;
    assign roc        = s_q.roc;
    assign pv_valid   = s_q.pv_valid;
    assign conv_start = s_q.conv_start;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_fault_range_flag: assert property (
        (f_ready && f_valid && range_fault(cfg.itype, f_data)) |-> ##5 flags.fault)
        else $error("range excess did not raise fault");
    a_clamp_temp_hi: assert property (
        (f_ready && f_valid && s_q.disc_conf && is_temp_grp(cfg.itype) && cfg.clamp_high)
        |=> s_q.code == C_P115)
        else $error("break clamp high wrong");
    a_break_confirm: assert property (
        $rose(s_q.disc_conf) |-> $past(s_q.disc_ms) + 13'h0001 >= $past(break_ms(cfg.itype)))
        else $error("break confirmed too early");
    a_break_loop_ma: assert property (
        (f_ready && f_valid && s_q.disc_conf && cfg.itype inside {PVC_I4_20, PVC_V1_5})
        |=> s_q.code == C_M15)
        else $error("loop break value wrong");
    a_break_bipolar: assert property (
        (f_ready && f_valid && s_q.disc_conf && cfg.itype inside {PVC_BIP, PVC_UV10})
        |=> s_q.code == C_MID && s_q.fault_p)
        else $error("bipolar break value wrong");
    a_avg_single: assert property (
        (s_q.st == ST_AVG && cfg.avg_n == 8'h01 && $stable(cfg)) |=> s_q.pv == $past(s_q.root))
        else $error("single-sample filter altered value");
    a_root_skipped: assert property (
        (s_q.st == ST_ROOT && !(cfg.scale_max > cfg.scale_min)) |=> s_q.root == $past(s_q.lin))
        else $error("root applied with inverted scaling");
    a_root_temp_off: assert property (
        (s_q.st == ST_ROOT && is_temp_grp(cfg.itype)) |=> s_q.root == $past(s_q.lin))
        else $error("root applied to temperature input");
    a_roc_per_conv: assert property (
        (s_q.st == ST_OUT && cfg.roc_s == 5'h00) |=> roc == sat16(36'($past(s_q.pv)) -
                                                              36'($past(s_q.last_pv))))
        else $error("per-conversion rate wrong");
    a_out_sequence: assert property (
        (f_ready && f_valid) |-> ##5 pv_valid ##1 !pv_valid)
        else $error("result pulse timing wrong");

    c_fault_seen: cover property (f_ready && f_valid && s_q.disc_conf);
    c_root_taken: cover property (s_q.st == ST_ROOT ##1 s_q.root != s_q.lin);
    c_alarm_rise: cover property ($rose(alm[0]));
    c_avg_full:   cover property (s_q.st == ST_AVG && s_q.cnt == AVG_MAX);
endmodule

// [pvc_pkg.sv]
// Shared constants and types of the process value conditioner
package pvc_pkg;
    localparam int CLK_HZ      = 250_000_000;
    localparam int TICK_MS     = 1;
    localparam int MS_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int SEC_MS      = 1000;
    localparam int FULL_SH     = 14;
    localparam int FULL        = 1 << FULL_SH; // 100% of span in code units
    localparam logic signed [17:0] C_P115  = 18'(FULL * 115 / 100);
    localparam logic signed [17:0] C_M15   = 18'(-(FULL * 15 / 100));
    localparam logic signed [17:0] C_P1075 = 18'(FULL * 1075 / 1000);
    localparam logic signed [17:0] C_M075  = 18'(-(FULL * 75 / 1000));
    localparam logic signed [17:0] C_ZERO  = 18'h00000;
    localparam logic signed [17:0] C_MID   = 18'(FULL / 2);
    localparam logic [12:0] DISC_RTD4_MS = 13'h1388; // 5 s
    localparam logic [12:0] DISC_MV_MS   = 13'h03E8; // 1 s
    localparam logic [12:0] DISC_OTH_MS  = 13'h01F4; // 0.5 s
    localparam logic [5:0]  DLY_MAX_S    = 6'h3C;    // 60 s
    localparam logic [4:0]  ROC_MAX_S    = 5'h10;    // 16 s
    localparam logic [7:0]  AVG_MAX      = 8'h80;    // 128 samples
    localparam int          SQRT_DROP    = 7;        // percent
    localparam logic [5:0]  CONV_A_MS    = 6'h3C;    // 60 ms
    localparam logic [5:0]  CONV_B_MS    = 6'h0A;    // 10 ms
    localparam logic [5:0]  CONV_C_MS    = 6'h05;    // 5 ms
    localparam int          FIFO_DEPTH   = 4;
    localparam int          CODE_W       = 18;

    typedef enum logic [3:0] {
        PVC_RTD4, PVC_RTD, PVC_TC, PVC_MV100, PVC_POT,
        PVC_I4_20, PVC_V1_5, PVC_V0_1V25, PVC_V0_5, PVC_V0_10,
        PVC_I0_20, PVC_BIP, PVC_UV10
    } pvc_input_type;

    typedef enum logic [1:0] {PVC_CONV_60, PVC_CONV_10, PVC_CONV_5} pvc_conv_type;

    typedef struct packed {
        pvc_input_type      itype;
        logic               clamp_high;
        logic [7:0]         avg_n;
        logic               sqrt_en;
        logic signed [15:0] scale_max;
        logic signed [15:0] scale_min;
        logic [4:0]         roc_s;     // 0: one conversion period
        pvc_conv_type       conv;
    } pvc_cfg_type;

    typedef struct packed {
        logic signed [15:0] upper_critical;
        logic signed [15:0] upper;
        logic signed [15:0] lower_critical;
        logic signed [15:0] lower;
        logic signed [15:0] roc_high;
        logic signed [15:0] roc_low;
        logic signed [15:0] hyst;
        logic [5:0]         delay_s;
    } pvc_alarm_cfg_type;

    typedef struct packed {
        logic fault;
        logic upper_critical_alarm;
        logic upper_alarm;
        logic lower_critical_alarm;
        logic lower_alarm;
        logic roc_high_alarm;
        logic roc_low_alarm;
    } pvc_flags_type;
endpackage

// [pvc_fifo.sv]
// Sample FIFO between the converter and the conditioner
`timescale 1ns/1ps
module pvc_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } pvc_fifo_state_type;

    pvc_fifo_state_type s_q;
    pvc_fifo_state_type s_d;
    logic               push;
    logic               pop;

    assign in_ready  = (s_q.cnt != (AW+1)'(D));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = (s_q.wp == AW'(D - 1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(D - 1)) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// [pvc_alarm.sv]
// One alarm comparator with hysteresis and on/off delay
`timescale 1ns/1ps
module pvc_alarm import pvc_pkg::*; (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               sec_tick,
    input  wire logic               upper,
    input  wire logic signed [15:0] value,
    input  wire logic signed [15:0] thresh,
    input  wire logic signed [15:0] hyst,
    input  wire logic [5:0]         delay_s,
    output logic                    active
);
    typedef struct packed {
        logic       act;
        logic [5:0] secs;
    } pvc_alm_state_type;

    pvc_alm_state_type  s_q;
    pvc_alm_state_type  s_d;
    logic signed [17:0] v;
    logic signed [17:0] lvl_on;
    logic signed [17:0] lvl_off;
    logic               on_c;
    logic               off_c;
    logic               want;
    logic [5:0]         dly;

    assign v       = 18'(value);
    assign lvl_on  = 18'(thresh);
    assign lvl_off = upper ? lvl_on - 18'(hyst) : lvl_on + 18'(hyst);
    assign on_c    = upper ? (v >= lvl_on) : (v <= lvl_on);
    assign off_c   = upper ? (v < lvl_off) : (v > lvl_off);
    assign want    = s_q.act ? !off_c : on_c;
    assign dly     = (delay_s > DLY_MAX_S) ? DLY_MAX_S : delay_s;
    assign active  = s_q.act;

    always_comb begin
        s_d = s_q;
        if (want == s_q.act) begin
            s_d.secs = '0;
        end else if (s_q.secs >= dly) begin
            s_d.act  = want;
            s_d.secs = '0;
        end else if (sec_tick) begin
            s_d.secs = s_q.secs + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_alarm_rise_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(s_q.act) |-> $past(on_c) && $past(s_q.secs) >= $past(dly))
        else $error("alarm rose without condition held for delay");
    a_alarm_fall_cause: assert property (@(posedge clk) disable iff (rst)
        $fell(s_q.act) |-> $past(off_c) && $past(s_q.secs) >= $past(dly))
        else $error("alarm fell without hysteresis release held for delay");
endmodule

// [pvc_src_model.sv]
// Converter-side sample source holding each code until taken
`timescale 1ns/1ps
module pvc_src_model import pvc_pkg::*; (
    input  wire logic                     clk,
    input  wire logic                     go,
    input  wire logic signed [CODE_W-1:0] code,
    input  wire logic                     smp_ready,
    output logic                          smp_valid,
    output logic signed [CODE_W-1:0]      smp_code
);
    logic taken;
    initial begin
        smp_valid = 1'b0;
        smp_code  = '0;
        taken     = 1'b0;
    end
    always @(posedge clk) taken <= smp_valid && smp_ready;
    // Released data shows its inverse so stale codes never look valid
    always @(negedge clk) begin
        if (taken) begin
            smp_valid <= 1'b0;
            smp_code  <= ~smp_code;
        end else if (go && !smp_valid) begin
            smp_valid <= 1'b1;
            smp_code  <= code;
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the process value conditioner
`timescale 1ns/1ps
module testbench import pvc_pkg::*; ;
    logic clk = 0, rst = 1, disc_pin = 0, go = 0, smp_valid, smp_ready, conv_start, pv_valid;
    logic signed [17:0] src_code = '0, smp_code;
    logic signed [15:0] pv, roc;
    pvc_cfg_type cfg = '{PVC_V0_10, 1'b0, 8'h01, 1'b0, 16'sh4000, 16'sh0000, 5'h00, PVC_CONV_5};
    pvc_alarm_cfg_type acfg = '{16'sh7FFF, 16'sh1F40, 16'sh8000, 16'sh8000,
                                16'sh7FFF, 16'sh8000, 16'sh0000, 6'h00};
    pvc_flags_type flags;
    int fails = 0, n_checks = 0;
    pvc_src_model src_u (.clk(clk), .go(go), .code(src_code), .smp_ready(smp_ready),
                         .smp_valid(smp_valid), .smp_code(smp_code));
    pvc_top #(.MS_CYCLES(1)) dut_u (.clk(clk), .rst(rst), .cfg(cfg), .acfg(acfg),
        .disc_pin(disc_pin), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .smp_code(smp_code), .conv_start(conv_start), .pv_valid(pv_valid), .pv(pv),
        .roc(roc), .flags(flags));
    initial forever #2 clk = ~clk;
    task automatic cmp16(string nm, logic signed [15:0] e, logic signed [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic cmp1(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic setc(pvc_input_type t, logic hi, logic [7:0] n, logic sq);
        @(negedge clk);
        cfg.itype <= t;
        cfg.clamp_high <= hi;
        cfg.avg_n <= n;
        cfg.sqrt_en <= sq;
    endtask
    task automatic run(logic signed [17:0] c, logic signed [15:0] ep, logic ef);
        int i;
        @(negedge clk);
        go <= 1'b1;
        src_code <= c;
        @(negedge clk);
        go <= 1'b0;
        for (i = 0; i < 40 && pv_valid !== 1'b1; i++) @(posedge clk) #1;
        cmp1("pv_valid", 1'b1, pv_valid);
        cmp16("pv", ep, pv);
        cmp1("fault", ef, flags.fault);
    endtask
    task automatic t_range;
        setc(PVC_V0_10, 0, 1, 0);
        run(18'sd8192, 16'sd8192, 0);
        run(18'sd18842, 16'sd18842, 1);
        run(-18'sd2458, -16'sd2458, 1);
        setc(PVC_I0_20, 0, 1, 0);
        run(-18'sd2458, -16'sd2458, 0);
        setc(PVC_BIP, 0, 1, 0);
        run(18'sd17613, 16'sd17613, 1);
        setc(PVC_TC, 0, 1, 0);
        run(18'sd18841, 16'sd18841, 0);
        $display("range test done");
    endtask
    task automatic t_avg_root;
        setc(PVC_V0_10, 0, 2, 0);
        run(18'sd0, 16'sd0, 0);
        run(18'sd16384, 16'sd8192, 0);
        setc(PVC_V0_10, 0, 1, 1);
        run(18'sd4096, 16'sd8192, 0);
        run(18'sd1000, 16'sd1000, 0);
        @(negedge clk) {cfg.scale_max, cfg.scale_min} <= {16'sh0000, 16'sh4000};
        run(-18'sd4096, 16'sd20480, 1);
        @(negedge clk) {cfg.scale_max, cfg.scale_min} <= {16'sh4000, 16'sh0000};
        setc(PVC_TC, 0, 1, 1);
        run(18'sd4096, 16'sd4096, 0);
        $display("average and root test done");
    endtask
    task automatic brk(pvc_input_type t, logic hi, logic signed [15:0] ep, logic ef);
        setc(t, hi, 1, 0);
        repeat (1100) @(negedge clk);
        run(18'sd8192, ep, ef);
    endtask
    task automatic t_break;
        setc(PVC_TC, 0, 1, 0);
        @(negedge clk) disc_pin <= 1'b1;
        repeat (300) @(negedge clk);
        run(18'sd8192, 16'sd8192, 0);
        brk(PVC_I4_20, 0, -16'sd2457, 1);
        brk(PVC_V1_5, 0, -16'sd2457, 1);
        brk(PVC_UV10, 0, 16'sd8192, 1);
        brk(PVC_TC, 1, 16'sd18841, 1);
        brk(PVC_TC, 0, -16'sd2457, 1);
        brk(PVC_V0_5, 0, 16'sd0, 1);
        brk(PVC_I0_20, 0, 16'sd0, 0);
        brk(PVC_BIP, 0, 16'sd8192, 1);
        @(negedge clk) disc_pin <= 1'b0;
        repeat (10) @(negedge clk);
        $display("break test done");
    endtask
    task automatic t_alarm;
        setc(PVC_V0_10, 0, 1, 0);
        run(18'sd1000, 16'sd1000, 0);
        repeat (4) @(posedge clk) #1;
        cmp1("upper_alarm", 1'b0, flags.upper_alarm);
        run(18'sd8192, 16'sd8192, 0);
        repeat (4) @(posedge clk) #1;
        cmp1("upper_alarm", 1'b1, flags.upper_alarm);
        cmp16("roc", 16'sd7192, roc);
        @(negedge clk) acfg.delay_s <= 6'h02;
        run(18'sd1000, 16'sd1000, 0);
        repeat (4) @(posedge clk) #1;
        cmp1("upper_alarm", 1'b1, flags.upper_alarm);
        repeat (2100) @(posedge clk) #1;
        cmp1("upper_alarm", 1'b0, flags.upper_alarm);
        $display("alarm test done");
    endtask
    task automatic t_conv;
        int k;
        for (int m = 0; m < 2; m++) begin
            @(negedge clk) cfg.conv <= pvc_conv_type'((m == 0) ? PVC_CONV_5 : PVC_CONV_10);
            repeat (20) @(posedge clk);
            k = 0;
            repeat (50) begin
                @(posedge clk) #1;
                if (conv_start === 1'b1) k++;
            end
            cmp16("conv_start count", (m == 0) ? 16'sd10 : 16'sd5, 16'(k));
        end
        $display("conversion timing test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst <= 1'b0;
        t_range;
        t_avg_root;
        t_break;
        t_alarm;
        t_conv;
        conclude;
    end
    initial begin
        #200000;
        fails++;
        conclude;
    end
endmodule
